// ===== hdl/brse_defines.svh
// Register addresses, field positions, reset values for the serial ROM checker
`ifndef BRSE_DEFINES_SVH
`define BRSE_DEFINES_SVH
`define BRSE_ADDR_LOG 40'hff00000018
`define BRSE_ADDR_TMO 40'hff00010088
`define BRSE_ERREN_BIT 24
`define BRSE_TIMEVAL_MSB 23
`define BRSE_TIMEVAL_RST 24'h200000
`define BRSE_ERREN_RST 1'b0
`define BRSE_LOG_PAR 1
`define BRSE_LOG_TOUT 0
`define BRSE_TMR_ZERO 24'h000000
`define BRSE_TMR_STEP 24'h000001
`define BRSE_REG_ZERO 64'h0000000000000000
`define BRSE_WORD_ZERO 32'h00000000
`endif

// ===== hdl/brse_pkg.sv
// Types shared by the serial ROM error and timeout checker
package brse_pkg;
  typedef logic [31:0] brse_word_t;
  typedef logic [63:0] brse_reg_t;
  typedef logic [39:0] brse_addr_t;
  typedef logic [23:0] brse_count_t;
  typedef enum logic [1:0] {
    BRSE_IDLE = 2'b00,
    BRSE_WAIT = 2'b01
  } brse_state_t;
endpackage

// ===== hdl/brse_timer.sv
// Down-counting timeout timer for the one outstanding link transaction
`timescale 1ns/100ps
`default_nettype none
`include "brse_defines.svh"
module brse_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control
  input wire logic load,
  input wire brse_pkg::brse_count_t reload,
  input wire logic run,
  // Status
  output var brse_pkg::brse_count_t count,
  output logic underflow
);
  import brse_pkg::*;

  // Underflow: a decrement is due while the count already sits at zero
  assign underflow = run && !load && (count == `BRSE_TMR_ZERO);

  // Load on issue, then step down once per cycle while waiting
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count <= `BRSE_TMR_ZERO;
    end else if (load) begin
      count <= reload;
    end else if (run && count != `BRSE_TMR_ZERO) begin
      count <= count - `BRSE_TMR_STEP;
    end
  end

  // Each waiting cycle with the count above zero takes exactly one off the count
  property p_timer_step;
    @(posedge clk_sys) disable iff (!reset_n)
      (run && !load && count != `BRSE_TMR_ZERO) |=>
        (count == $past(count) - `BRSE_TMR_STEP);
  endproperty
  a_timer_step: assert property (p_timer_step)
    else $error("timer did not step down by one");
endmodule
`default_nettype wire

// ===== hdl/brse_top.sv
// Serial boot ROM link error and timeout supervisor with its registers
// Function
// - Only one link transaction outstanding at once
// - Load timer from reload, decrement each cycle
// - Timer underflow before completion means timeout
// - Parity on link traffic; odd response errors
// - Parity-errored read returns data, error tagged
// - Timed-out read returns zeros, error tagged
// - Errors raise trap request when enable set
// - Read error tag ignores the enable bit
// - Logging and trap both gated by enable
// - Enable is timeout register bit 24
// - Reload field bits 23:0, reset 200000 hex
// - Log bit 1 parity, write-one clears
// - Log bit 0 timeout, write-one clears
`timescale 1ns/100ps
`default_nettype none
`include "brse_defines.svh"
module brse_top (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire brse_pkg::brse_addr_t reg_addr,
  input wire brse_pkg::brse_reg_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output var brse_pkg::brse_reg_t reg_rdata,
  // Requester side
  input wire logic req_valid,
  input wire logic req_write,
  input wire brse_pkg::brse_word_t req_data,
  output logic req_ready,
  output logic rsp_valid,
  output var brse_pkg::brse_word_t rsp_data,
  output logic rsp_error,
  // Boot ROM link side
  output logic link_req_valid,
  output logic link_req_write,
  output var brse_pkg::brse_word_t link_req_data,
  output logic link_req_parity,
  input wire logic link_rsp_valid,
  input wire brse_pkg::brse_word_t link_rsp_data,
  input wire logic link_rsp_parity,
  // Error interrupt request, interrupt line bit 1
  output logic err_trap
);
  import brse_pkg::*;

  brse_state_t state; // Link transaction state
  logic cur_write; // Outstanding transaction is a write
  logic err_en; // Error logging and trap enable
  brse_count_t time_reload; // Timeout reload value
  logic log_par; // Sticky parity error flag
  logic log_tout; // Sticky timeout flag
  brse_count_t tmr_count; // Timer value, seen by checks
  logic tmr_under; // Timer underflow this cycle
  logic accept; // Request taken this cycle
  logic busy; // A transaction is outstanding
  logic got_rsp; // Response arrives while waiting
  logic par_bad; // Response parity is odd
  logic tout_evt; // Timeout this cycle
  logic par_evt; // Parity error this cycle
  logic wr_tmo; // Write to timeout register
  logic wr_log; // Write to log register

  assign busy = (state == BRSE_WAIT);
  assign accept = req_valid && req_ready;
  assign got_rsp = busy && link_rsp_valid;
  // Data and parity together must sum even; odd means corruption
  assign par_bad = ^{link_rsp_data, link_rsp_parity};
  assign par_evt = got_rsp && par_bad;
  // A response in the underflow cycle still completes the transaction
  assign tout_evt = tmr_under && !link_rsp_valid;
  assign wr_tmo = reg_wr && (reg_addr == `BRSE_ADDR_TMO);
  assign wr_log = reg_wr && (reg_addr == `BRSE_ADDR_LOG);

  // Timeout timer; it only runs while waiting and is reloaded per issue
  brse_timer u_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(accept),
    .reload(time_reload),
    .run(busy),
    .count(tmr_count),
    .underflow(tmr_under)
  );

  // Transaction state: idle until taken, wait until answer or timeout
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= BRSE_IDLE;
      cur_write <= 1'b0;
    end else begin
      case (state)
        BRSE_IDLE: begin
          if (accept) begin
            state <= BRSE_WAIT;
            cur_write <= req_write;
          end
        end
        BRSE_WAIT: begin
          // Completion or timeout discards the timer
          if (got_rsp || tout_evt) begin
            state <= BRSE_IDLE;
          end
        end
        default: begin
          state <= BRSE_IDLE;
        end
      endcase
    end
  end

  // Ready only when idle and not just taking a request
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'b0;
    end else if (accept) begin
      req_ready <= 1'b0;
    end else if (busy && (got_rsp || tout_evt)) begin
      req_ready <= 1'b1;
    end else if (state == BRSE_IDLE) begin
      req_ready <= 1'b1;
    end
  end

  // Issue onto the link with even parity over the data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      link_req_valid <= 1'b0;
      link_req_write <= 1'b0;
      link_req_data <= `BRSE_WORD_ZERO;
      link_req_parity <= 1'b0;
    end else begin
      link_req_valid <= accept;
      if (accept) begin
        link_req_write <= req_write;
        link_req_data <= req_data;
        link_req_parity <= ^req_data;
      end
    end
  end

  // Answer to requester; reads carry an error tag whatever the enable
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid <= 1'b0;
      rsp_data <= `BRSE_WORD_ZERO;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= got_rsp || tout_evt;
      if (got_rsp) begin
        // Corrupt read data is still handed back, only tagged
        rsp_data <= cur_write ? `BRSE_WORD_ZERO : link_rsp_data;
        rsp_error <= par_bad && !cur_write;
      end else if (tout_evt) begin
        // Zeros on a timed-out fetch tend to trap as illegal opcode
        rsp_data <= `BRSE_WORD_ZERO;
        rsp_error <= !cur_write;
      end else begin
        rsp_error <= 1'b0;
      end
    end
  end

  // Error trap request pulse, only with the enable set
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      err_trap <= 1'b0;
    end else begin
      err_trap <= err_en && (par_evt || tout_evt);
    end
  end

  // Timeout control register: enable and reload value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      err_en <= `BRSE_ERREN_RST;
      time_reload <= `BRSE_TIMEVAL_RST;
    end else if (wr_tmo) begin
      err_en <= reg_wdata[`BRSE_ERREN_BIT];
      time_reload <= reg_wdata[`BRSE_TIMEVAL_MSB:0];
    end
  end

  // Sticky log flags; a new event beats a same-cycle clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      log_par <= 1'b0;
      log_tout <= 1'b0;
    end else begin
      if (err_en && par_evt) begin
        log_par <= 1'b1;
      end else if (wr_log && reg_wdata[`BRSE_LOG_PAR]) begin
        log_par <= 1'b0;
      end
      if (err_en && tout_evt) begin
        log_tout <= 1'b1;
      end else if (wr_log && reg_wdata[`BRSE_LOG_TOUT]) begin
        log_tout <= 1'b0;
      end
    end
  end

  // Read data one cycle after the strobe; reserved bits and holes read 0
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= `BRSE_REG_ZERO;
    end else if (!reg_rd) begin
      reg_rdata <= `BRSE_REG_ZERO;
    end else if (reg_addr == `BRSE_ADDR_TMO) begin
      reg_rdata <= `BRSE_REG_ZERO;
      reg_rdata[`BRSE_ERREN_BIT] <= err_en;
      reg_rdata[`BRSE_TIMEVAL_MSB:0] <= time_reload;
    end else if (reg_addr == `BRSE_ADDR_LOG) begin
      reg_rdata <= `BRSE_REG_ZERO;
      reg_rdata[`BRSE_LOG_PAR] <= log_par;
      reg_rdata[`BRSE_LOG_TOUT] <= log_tout;
    end else begin
      reg_rdata <= `BRSE_REG_ZERO;
    end
  end

  // A taken request closes the door until the answer
  property p_single;
    @(posedge clk_sys) disable iff (!reset_n)
      accept |=> (!req_ready && busy);
  endproperty
  a_single: assert property (p_single)
    else $error("second transaction could be taken");

  // Timer starts from the programmed reload value
  property p_load;
    @(posedge clk_sys) disable iff (!reset_n)
      accept |=> (tmr_count == $past(time_reload));
  endproperty
  a_load: assert property (p_load)
    else $error("timer not loaded from reload field");

  // Underflow without answer ends the wait with an answer
  property p_timeout;
    @(posedge clk_sys) disable iff (!reset_n)
      (busy && tmr_under && !link_rsp_valid) |=>
        (rsp_valid && state == BRSE_IDLE);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not complete transaction");

  // Bad-parity read returns the received word tagged
  property p_par_read;
    @(posedge clk_sys) disable iff (!reset_n)
      (par_evt && !cur_write) |=>
        (rsp_valid && rsp_error && rsp_data == $past(link_rsp_data));
  endproperty
  a_par_read: assert property (p_par_read)
    else $error("parity read not returned with tag");

  // Timed-out read returns zeros tagged
  property p_tout_read;
    @(posedge clk_sys) disable iff (!reset_n)
      (tout_evt && !cur_write) |=>
        (rsp_error && rsp_data == `BRSE_WORD_ZERO);
  endproperty
  a_tout_read: assert property (p_tout_read)
    else $error("timed out read not zero with tag");

  // No trap while the enable is clear
  property p_trap_gate;
    @(posedge clk_sys) disable iff (!reset_n)
      err_trap |-> $past(err_en);
  endproperty
  a_trap_gate: assert property (p_trap_gate)
    else $error("trap raised with enable clear");

  // Any error with enable set gives a trap next cycle
  property p_trap;
    @(posedge clk_sys) disable iff (!reset_n)
      (err_en && (par_evt || tout_evt)) |=> err_trap;
  endproperty
  a_trap: assert property (p_trap)
    else $error("missing error trap");

  // Enabled parity error leaves the flag set
  property p_log_par;
    @(posedge clk_sys) disable iff (!reset_n)
      (err_en && par_evt) |=> log_par;
  endproperty
  a_log_par: assert property (p_log_par)
    else $error("parity flag not set");

  // Enabled timeout leaves the flag set
  property p_log_tout;
    @(posedge clk_sys) disable iff (!reset_n)
      (err_en && tout_evt) |=> log_tout;
  endproperty
  a_log_tout: assert property (p_log_tout)
    else $error("timeout flag not set");
endmodule
`default_nettype wire

// ===== verif/brse_rom_model.sv
// Behavioural serial boot ROM on the far side of the link
`timescale 1ns/100ps
`default_nettype none
module brse_rom_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Request strobe from the supervisor
  input wire logic link_req_valid,
  // Answer control from the bench
  input wire logic [2:0] delay,
  input wire logic bad,
  input wire logic mute,
  input wire logic [31:0] word,
  // Responses
  output logic link_rsp_valid,
  output logic [31:0] link_rsp_data,
  output logic link_rsp_parity
);
  logic [2:0] cnt; // Cycles left before the answer
  logic fire; // Answer goes out on the coming edge
  assign fire = (link_req_valid && !mute && delay == 3'h1) ||
                (!link_req_valid && cnt == 3'h1);
  // One answer per request, writes included; mute models a dead ROM
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 3'h0;
      link_rsp_valid <= 1'b0;
      link_rsp_data <= 32'h0;
      link_rsp_parity <= 1'b0;
    end else begin
      // Released lines toggle so stale data never looks like an answer
      link_rsp_valid <= 1'b0;
      link_rsp_data <= ~link_rsp_data;
      link_rsp_parity <= ~link_rsp_parity;
      if (link_req_valid && !mute) begin
        cnt <= delay - 3'h1;
      end else if (cnt != 3'h0) begin
        cnt <= cnt - 3'h1;
      end
      if (fire) begin
        link_rsp_valid <= 1'b1;
        link_rsp_data <= word;
        link_rsp_parity <= ^word ^ bad;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/brse_top_test.sv
// Self-checking bench for the serial boot ROM error supervisor
`timescale 1ns/100ps
`default_nettype none
`include "brse_defines.svh"
module brse_top_test;
  import brse_pkg::*;
  // Stimulus and observed signals
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  brse_addr_t reg_addr = 40'h0;
  brse_reg_t reg_wdata = 64'h0;
  brse_reg_t reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic req_ready, rsp_valid, rsp_error, err_trap;
  brse_word_t req_data = 32'h0, rom_word = 32'h0;
  brse_word_t rsp_data, link_req_data, link_rsp_data;
  logic link_req_valid, link_req_write, link_req_parity;
  logic link_rsp_valid, link_rsp_parity;
  logic [2:0] rom_delay = 3'h1;
  logic rom_bad = 1'b0, rom_mute = 1'b0, rd_pend = 1'b0, en = 1'b0;
  // Expectations, oldest first
  logic [32:0] exp_rsp[$];
  brse_reg_t exp_reg[$];
  int err_total = 0, checks = 0, traps = 0, exp_traps = 0;
  int issued = 0, cyc = 0;

  always #5 clk_sys = ~clk_sys;

  brse_top DUT (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_valid(req_valid), .req_write(req_write),
    .req_data(req_data), .req_ready(req_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_error(rsp_error),
    .link_req_valid(link_req_valid), .link_req_write(link_req_write),
    .link_req_data(link_req_data), .link_req_parity(link_req_parity),
    .link_rsp_valid(link_rsp_valid), .link_rsp_data(link_rsp_data),
    .link_rsp_parity(link_rsp_parity), .err_trap(err_trap));

  brse_rom_model ROM (
    .clk_sys(clk_sys), .reset_n(reset_n), .link_req_valid(link_req_valid),
    .delay(rom_delay), .bad(rom_bad), .mute(rom_mute), .word(rom_word),
    .link_rsp_valid(link_rsp_valid), .link_rsp_data(link_rsp_data),
    .link_rsp_parity(link_rsp_parity));

  // Compare one value and count the outcome
  task automatic check(input string what, input logic [63:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard: a run this long means a lost handshake
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      conclude();
    end
  end

  // Monitor at mid-cycle, where every registered output has settled
  always @(negedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      check("rsp", 64'({rsp_error, rsp_data}),
            64'(exp_rsp.pop_front()));
    end
    if (rd_pend) begin
      check("rdata", reg_rdata, exp_reg.pop_front());
    end
    rd_pend = reg_rd;
    if (err_trap === 1'b1) begin
      traps++;
    end
    if (link_req_valid === 1'b1) begin
      issued++;
      // Parity is predicted from what the bench asked for, not what went out
      check("lpar", {63'h0, link_req_parity}, {63'h0, ^req_data});
      check("lwr", {63'h0, link_req_write}, {63'h0, req_write});
      check("ldat", {32'h0, link_req_data}, {32'h0, req_data});
    end
  end

  // One register cycle; a read notes its expected data
  task automatic reg_op(input logic wr, input brse_addr_t a,
                        input brse_reg_t d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= wr;
    reg_rd <= !wr;
    if (!wr) begin
      exp_reg.push_back(d);
    end
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask

  // One link transaction with the ROM answering as commanded
  task automatic xfer(input logic wr, input brse_word_t w,
                      input logic [2:0] d, input logic bad, input logic mute);
    int n;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_write <= wr;
    req_data <= w;
    rom_word <= w;
    rom_delay <= d;
    rom_bad <= bad;
    rom_mute <= mute;
    // Writes report nothing; a timed-out read returns zeros
    exp_rsp.push_back(wr ? 33'h0 : {mute | bad, mute ? 32'h0 : w});
    if (en && (bad || mute)) begin
      exp_traps++;
    end
    issued = 0;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    // A request never taken counts as a failure, not a silent skip
    check("rdywait", 64'(n < 50), 64'h1);
    req_valid <= 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
    // A missing answer counts as a failure
    check("rspwait", 64'(n < 50), 64'h1);
    @(negedge clk_sys);
    check("traps", 64'(traps), 64'(exp_traps));
    check("issued", 64'(issued), 64'h1);
  endtask

  initial begin
    void'($urandom(32'h70ffb87e));
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    reg_op(1'b0, `BRSE_ADDR_TMO, 64'h0000000000200000);
    reg_op(1'b0, `BRSE_ADDR_LOG, 64'h0);
    reg_op(1'b0, 40'hff00000020, 64'h0);
    reg_op(1'b1, `BRSE_ADDR_TMO, 64'hfffffffffe000004);
    reg_op(1'b0, `BRSE_ADDR_TMO, 64'h0000000000000004);
    $display("test registers done");
    xfer(1'b0, 32'h12345678, 3'h1, 1'b0, 1'b1);
    xfer(1'b0, 32'ha5a5a5a5, 3'h2, 1'b1, 1'b0);
    xfer(1'b1, 32'h0000beef, 3'h3, 1'b1, 1'b0);
    reg_op(1'b0, `BRSE_ADDR_LOG, 64'h0);
    $display("test errors disabled done");
    en = 1'b1;
    reg_op(1'b1, `BRSE_ADDR_TMO, 64'h0000000001000004);
    for (int i = 0; i < 8; i++) begin
      // Delays stay inside the timeval of 4; delays 1 to 3 beat the timer, delay 4 lands in the underflow cycle and still wins
      xfer(i[0], $urandom, 3'($urandom_range(4, 1)), 1'b0, 1'b0);
    end
    // Answer lands in the very underflow cycle and must still win
    xfer(1'b0, 32'h0f0f0f0f, 3'h4, 1'b0, 1'b0);
    xfer(1'b0, 32'h00000001, 3'h1, 1'b1, 1'b0);
    xfer(1'b1, 32'hdeadbeef, 3'h1, 1'b0, 1'b1);
    xfer(1'b1, 32'h00000003, 3'h4, 1'b1, 1'b0);
    reg_op(1'b0, `BRSE_ADDR_LOG, 64'h3);
    reg_op(1'b1, `BRSE_ADDR_LOG, 64'h2);
    reg_op(1'b0, `BRSE_ADDR_LOG, 64'h1);
    reg_op(1'b1, `BRSE_ADDR_LOG, 64'h1);
    reg_op(1'b0, `BRSE_ADDR_LOG, 64'h0);
    $display("test errors enabled done");
    check("pending", 64'(exp_rsp.size()), 64'h0);
    conclude();
  end
endmodule
`default_nettype wire
